// ---- ntb_cfg_header.sv ----
// Type 0 configuration header of the external endpoint side of the bridge.
`timescale 1ns/100ps
`include "ntb_cfg_map.svh"

module ntb_cfg_header
  import ntb_cfg_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE   = 16'h1234,  // Arbitrary value.
  parameter logic [15:0] PART_CODE     = 16'h5678,  // Arbitrary value.
  parameter logic [7:0]  REVISION_INIT = 8'h00
) (
  input  wire logic           CLOCK,
  input  wire logic           RST_B,
  input  wire ntb_cfg_req_t   CFG_REQ,
  output logic                CFG_ACK,
  output logic [31:0]         CFG_RDATA,
  input  wire ntb_win_setup_t WINDOW0_SETUP,
  input  wire ntb_events_t    EVENTS,
  input  wire logic           OWN_IRQ_PENDING,
  input  wire ntb_traffic_t   TRAFFIC,
  output logic                IO_ACCEPT,
  output logic                MEM_ACCEPT,
  output logic                FWD_ALLOW,
  output logic                FWD_REPLY_UR,
  output logic                ERR_MSG_SEND,
  output logic [63:0]         WINDOW0_BASE,
  output logic [63:0]         WINDOW0_MASK
);

  // Bits of the base that the configured window size lets software write.
  function automatic logic [63:0] win_mask(input ntb_win_setup_t s);
    logic [63:0] m;
    m = 64'h0000_0000_0000_0000;
    for (int i = `NTB_BASE_LSB; i < 64; i++) begin
      m[i] = (s.size_log2 != 6'h00) && (i >= int'(s.size_log2));
    end
    // Upper half only exists for a 64-bit memory window.
    if (s.space_select || (s.addr_type != `NTB_ADDR_TYPE_64)) begin
      m[63:32] = 32'h0000_0000;
    end
    return m;
  endfunction

  // Byte-enable merge for a written dword.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [15:0] command;
  logic [15:0] status_w1c;
  logic [7:0]  revision_code;
  logic [7:0]  line_size_hint;
  logic [63:0] base;
  logic        err_sent;
  logic        cfg_ack;
  logic [31:0] cfg_rdata;

  logic [15:0] next_command;
  logic [15:0] next_status_w1c;
  logic [7:0]  next_revision_code;
  logic [7:0]  next_line_size_hint;
  logic [63:0] next_base;
  logic        next_err_sent;
  logic        next_cfg_ack;
  logic [31:0] next_cfg_rdata;

  logic [63:0] mask;
  logic        wide_mode;
  logic        io_mode;
  logic [15:0] status_view;
  logic [31:0] win0_view;
  logic [31:0] win1_view;
  logic        wr;
  logic [15:0] w1c_hit;
  logic [15:0] set_bits;

  assign mask      = win_mask(WINDOW0_SETUP);
  assign io_mode   = WINDOW0_SETUP.space_select;
  assign wide_mode = !io_mode && (WINDOW0_SETUP.addr_type == `NTB_ADDR_TYPE_64);
  assign wr        = CFG_REQ.valid && CFG_REQ.write;

  // Status as read: flags, live interrupt level and the fixed capability bit.
  always_comb begin
    status_view = status_w1c;
    status_view[`NTB_STS_LEGACY_IRQ_PEND] = OWN_IRQ_PENDING;
    status_view[`NTB_STS_CAP_LIST_FLAG]   = 1'b1;
  end

  // Masking on read too, so a size change hides stale high-resolution bits at once.
  always_comb begin
    win0_view = base[31:0] & mask[31:0];
    win0_view[0] = WINDOW0_SETUP.space_select;
    win0_view[2:1] = io_mode ? 2'h0 : WINDOW0_SETUP.addr_type;
    win0_view[3]   = io_mode ? 1'b0 : WINDOW0_SETUP.fetch_ahead_flag;
    // The second base dword holds the upper half of window 0 in 64-bit memory mode and reads zero otherwise.
    win1_view = wide_mode ? (base[63:32] & mask[63:32]) : 32'h0000_0000;
  end

  // Hardware sets for the write-one-to-clear flags.
  always_comb begin
    set_bits = 16'h0000;
    set_bits[`NTB_STS_MASTER_POISON]  = EVENTS.poison_cpl_or_wr
                                        && command[`NTB_CMD_POISON_REPORT_EN];
    set_bits[`NTB_STS_GOT_CPL_ABORT]  = EVENTS.got_cpl_abort;
    set_bits[`NTB_STS_GOT_UNSUP_REQ]  = EVENTS.got_unsup_req;
    set_bits[`NTB_STS_SENT_SYS_ERROR] = err_sent;
    set_bits[`NTB_STS_POISON_SEEN]    = EVENTS.poison_tlp;
  end

  always_comb begin
    w1c_hit = 16'h0000;
    if (wr && (CFG_REQ.dword == 10'(`NTB_OFS_COMMAND_CONTROL >> 2)) && CFG_REQ.byte_en[3]) begin
      w1c_hit[15:8] = CFG_REQ.wdata[31:24];
    end
  end

  always_comb begin
    logic [31:0] merged;
    merged              = 32'h0000_0000;
    next_command        = command;
    next_revision_code  = revision_code;
    next_line_size_hint = line_size_hint;
    next_base           = base;
    next_cfg_ack        = CFG_REQ.valid;
    next_cfg_rdata      = 32'h0000_0000;
    // Set wins over a clear in the same cycle so no event is lost.
    next_status_w1c = ((status_w1c & ~w1c_hit) | set_bits) & {8'hF1, 8'h00};
    next_err_sent   = EVENTS.error_detected && command[`NTB_CMD_ERROR_MSG_EN];
    if (wr) begin
      if (CFG_REQ.dword == 10'(`NTB_OFS_COMMAND_CONTROL >> 2)) begin
        merged = lane_merge({16'h0000, command}, CFG_REQ.wdata, CFG_REQ.byte_en);
        next_command = 16'h0000;
        next_command[`NTB_CMD_IO_SPACE_EN]      = merged[`NTB_CMD_IO_SPACE_EN];
        next_command[`NTB_CMD_MEM_SPACE_EN]     = merged[`NTB_CMD_MEM_SPACE_EN];
        next_command[`NTB_CMD_REQ_FORWARD_EN]   = merged[`NTB_CMD_REQ_FORWARD_EN];
        next_command[`NTB_CMD_POISON_REPORT_EN] = merged[`NTB_CMD_POISON_REPORT_EN];
        next_command[`NTB_CMD_ERROR_MSG_EN]     = merged[`NTB_CMD_ERROR_MSG_EN];
        next_command[`NTB_CMD_LEGACY_IRQ_OFF]   = merged[`NTB_CMD_LEGACY_IRQ_OFF];
      end else if (CFG_REQ.dword == 10'(`NTB_OFS_REVISION_CODE >> 2)) begin
        if (CFG_REQ.byte_en[0]) begin
          next_revision_code = CFG_REQ.wdata[7:0];
        end
      end else if (CFG_REQ.dword == 10'(`NTB_OFS_LINE_SIZE_HINT >> 2)) begin
        if (CFG_REQ.byte_en[0]) begin
          next_line_size_hint = CFG_REQ.wdata[7:0];
        end
      end else if (CFG_REQ.dword == 10'(`NTB_OFS_WINDOW0_BASE >> 2)) begin
        merged = lane_merge(base[31:0], CFG_REQ.wdata, CFG_REQ.byte_en);
        next_base[31:0] = merged & mask[31:0];
      end else if (CFG_REQ.dword == 10'(`NTB_OFS_WINDOW1_BASE >> 2)) begin
        if (wide_mode) begin
          merged = lane_merge(base[63:32], CFG_REQ.wdata, CFG_REQ.byte_en);
          next_base[63:32] = merged & mask[63:32];
        end
      end
    end
    if (CFG_REQ.valid && !CFG_REQ.write) begin
      if (CFG_REQ.dword == 10'(`NTB_OFS_MAKER_IDENTITY >> 2)) begin
        next_cfg_rdata = {PART_CODE, VENDOR_CODE};
      end else if (CFG_REQ.dword == 10'(`NTB_OFS_COMMAND_CONTROL >> 2)) begin
        next_cfg_rdata = {status_view, command};
      end else if (CFG_REQ.dword == 10'(`NTB_OFS_REVISION_CODE >> 2)) begin
        next_cfg_rdata = {`NTB_BASE_CLASS, `NTB_SUB_CLASS, `NTB_PROG_INTERFACE, revision_code};
      end else if (CFG_REQ.dword == 10'(`NTB_OFS_LINE_SIZE_HINT >> 2)) begin
        next_cfg_rdata = {`NTB_SELF_TEST, `NTB_HEADER_LAYOUT, `NTB_LATENCY_TIMER,
                          line_size_hint};
      end else if (CFG_REQ.dword == 10'(`NTB_OFS_WINDOW0_BASE >> 2)) begin
        next_cfg_rdata = win0_view;
      end else if (CFG_REQ.dword == 10'(`NTB_OFS_WINDOW1_BASE >> 2)) begin
        next_cfg_rdata = win1_view;
      end else begin
        next_cfg_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      command        <= `NTB_RST_COMMAND;
      status_w1c     <= `NTB_RST_STATUS_W1C;
      revision_code  <= REVISION_INIT;
      line_size_hint <= `NTB_RST_LINE_SIZE;
      base           <= `NTB_RST_BASE;
      err_sent       <= 1'b0;
      cfg_ack        <= 1'b0;
      cfg_rdata      <= 32'h0000_0000;
    end else begin
      command        <= next_command;
      status_w1c     <= next_status_w1c;
      revision_code  <= next_revision_code;
      line_size_hint <= next_line_size_hint;
      base           <= next_base;
      err_sent       <= next_err_sent;
      cfg_ack        <= next_cfg_ack;
      cfg_rdata      <= next_cfg_rdata;
    end
  end

  assign CFG_ACK      = cfg_ack;
  assign CFG_RDATA    = cfg_rdata;
  assign ERR_MSG_SEND = err_sent;
  assign WINDOW0_BASE = {wide_mode ? win1_view : 32'h0000_0000, win0_view[31:4], 4'h0};
  assign WINDOW0_MASK = mask;

  // Traffic gating toward the transaction layer; combinational so a hit is judged this cycle.
  assign IO_ACCEPT    = TRAFFIC.io_hit && command[`NTB_CMD_IO_SPACE_EN];
  assign MEM_ACCEPT   = TRAFFIC.mem_hit && command[`NTB_CMD_MEM_SPACE_EN];
  assign FWD_ALLOW    = TRAFFIC.fwd_req && command[`NTB_CMD_REQ_FORWARD_EN];
  assign FWD_REPLY_UR = TRAFFIC.fwd_req && TRAFFIC.fwd_nonposted
                        && !command[`NTB_CMD_REQ_FORWARD_EN];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  a_ack_one_cycle: assert property (CFG_REQ.valid |=> CFG_ACK)
    else $error("Configuration request not acknowledged after one cycle.");

  a_io_gate_off: assert property (!command[`NTB_CMD_IO_SPACE_EN] |-> !IO_ACCEPT)
    else $error("I/O request accepted while I/O space is disabled.");

  a_mem_gate_on: assert property (TRAFFIC.mem_hit && !MEM_ACCEPT |-> !command[`NTB_CMD_MEM_SPACE_EN])
    else $error("Memory hit refused while memory space is enabled.");

  a_fwd_ur_pair: assert property (TRAFFIC.fwd_req |-> (FWD_ALLOW != (FWD_REPLY_UR || !TRAFFIC.fwd_nonposted))
                                  || command[`NTB_CMD_REQ_FORWARD_EN])
    else $error("Forwarding gate and unsupported reply disagree.");

  a_poison_gate: assert property ($rose(status_w1c[`NTB_STS_MASTER_POISON]) |->
                                  $past(command[`NTB_CMD_POISON_REPORT_EN]) && $past(EVENTS.poison_cpl_or_wr))
    else $error("Master poison flag set without enable and event.");

  a_poison_always: assert property (EVENTS.poison_tlp |=> status_w1c[`NTB_STS_POISON_SEEN])
    else $error("Poisoned packet not recorded.");

  a_sse_follow: assert property (EVENTS.error_detected && command[`NTB_CMD_ERROR_MSG_EN]
                                 |=> ERR_MSG_SEND ##1 status_w1c[`NTB_STS_SENT_SYS_ERROR])
    else $error("Error message not sent or not flagged.");

  a_abort_hold: assert property (status_w1c[`NTB_STS_GOT_CPL_ABORT] && !w1c_hit[`NTB_STS_GOT_CPL_ABORT]
                                 |=> status_w1c[`NTB_STS_GOT_CPL_ABORT])
    else $error("Completer abort flag lost without a write of one.");

  a_ur_clear: assert property (w1c_hit[`NTB_STS_GOT_UNSUP_REQ] && !EVENTS.got_unsup_req
                               |=> !status_w1c[`NTB_STS_GOT_UNSUP_REQ])
    else $error("Unsupported request flag not cleared by a write of one.");

  a_cap_flag: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.dword == 10'h001
                               |=> CFG_RDATA[16 + `NTB_STS_CAP_LIST_FLAG] && CFG_RDATA[27:25] == 3'h0
                                   && CFG_RDATA[23:21] == 3'h0 && CFG_RDATA[18:16] == 3'h0)
    else $error("Capability flag or fixed status bits read wrong.");

  a_class_read: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.dword == 10'h002
                                 |=> CFG_RDATA[31:8] == 24'h06_8000)
    else $error("Class code read wrong.");

  a_base_masked: assert property (wr && CFG_REQ.dword == 10'h004
                                  |=> (base[31:0] & ~$past(mask[31:0])) == 32'h0000_0000)
    else $error("Base holds bits the window size forbids.");

  a_io_type_zero: assert property (io_mode |-> win0_view[3:1] == 3'h0 && win1_view == 32'h0000_0000)
    else $error("I/O window shows type or prefetch bits.");

  // Gates other than FWD_ALLOW are checked in both directions; FWD_ALLOW is only checked to stay low while forwarding is off.
  a_io_gate_on: assert property (TRAFFIC.io_hit && command[`NTB_CMD_IO_SPACE_EN] |-> IO_ACCEPT)
    else $error("I/O hit refused while I/O space is enabled.");

  a_mem_gate_off: assert property (!command[`NTB_CMD_MEM_SPACE_EN] |-> !MEM_ACCEPT)
    else $error("Memory request accepted while memory space is disabled.");

  a_fwd_blocked: assert property (!command[`NTB_CMD_REQ_FORWARD_EN] |-> !FWD_ALLOW)
    else $error("Request forwarded while forwarding is disabled.");

  a_fwd_ur_reply: assert property (TRAFFIC.fwd_req && TRAFFIC.fwd_nonposted
                                   && !command[`NTB_CMD_REQ_FORWARD_EN] |-> FWD_REPLY_UR)
    else $error("Blocked non-posted request not answered as unsupported.");

  a_fwd_ur_quiet: assert property (!TRAFFIC.fwd_nonposted || command[`NTB_CMD_REQ_FORWARD_EN] |-> !FWD_REPLY_UR)
    else $error("Unsupported reply raised without a blocked non-posted request.");

  // Flag checks: every set path and every clear path except the completer abort clear has its own property.
  a_poison_set: assert property (EVENTS.poison_cpl_or_wr && command[`NTB_CMD_POISON_REPORT_EN]
                                 |=> status_w1c[`NTB_STS_MASTER_POISON])
    else $error("Enabled poisoned completion or write not recorded.");

  a_mdpe_clear: assert property (w1c_hit[`NTB_STS_MASTER_POISON] && !set_bits[`NTB_STS_MASTER_POISON]
                                 |=> !status_w1c[`NTB_STS_MASTER_POISON])
    else $error("Master poison flag not cleared by a write of one.");

  a_err_msg_gate: assert property (!command[`NTB_CMD_ERROR_MSG_EN] |=> !ERR_MSG_SEND)
    else $error("Error message sent while error reporting is disabled.");

  a_abort_set: assert property (EVENTS.got_cpl_abort |=> status_w1c[`NTB_STS_GOT_CPL_ABORT])
    else $error("Completer abort not recorded.");

  a_ur_set: assert property (EVENTS.got_unsup_req |=> status_w1c[`NTB_STS_GOT_UNSUP_REQ])
    else $error("Unsupported request completion not recorded.");

  a_sse_source: assert property ($rose(status_w1c[`NTB_STS_SENT_SYS_ERROR]) |-> $past(ERR_MSG_SEND))
    else $error("System error flag set without a sent error message.");

  a_sse_clear: assert property (w1c_hit[`NTB_STS_SENT_SYS_ERROR] && !err_sent
                                |=> !status_w1c[`NTB_STS_SENT_SYS_ERROR])
    else $error("System error flag not cleared by a write of one.");

  a_dpe_clear: assert property (w1c_hit[`NTB_STS_POISON_SEEN] && !EVENTS.poison_tlp
                                |=> !status_w1c[`NTB_STS_POISON_SEEN])
    else $error("Poison flag not cleared by a write of one.");

  a_cmd_fixed_zero: assert property ((command & 16'hFAB8) == 16'h0000)
    else $error("Read-only command bit became one.");

  // Read checks take the request-edge inputs through $past, since they may move before the answer.
  a_irq_view: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.dword == 10'h001
                               |=> CFG_RDATA[16 + `NTB_STS_LEGACY_IRQ_PEND] == $past(OWN_IRQ_PENDING))
    else $error("Interrupt status bit does not follow the own pending level.");

  a_line_size_keep: assert property (wr && CFG_REQ.dword == 10'h003 && CFG_REQ.byte_en[0]
                                     |=> line_size_hint == $past(CFG_REQ.wdata[7:0]))
    else $error("Line size hint did not store the written byte.");

  a_fixed_bytes: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.dword == 10'h003
                                  |=> CFG_RDATA[31:8] == 24'h00_0000)
    else $error("Latency, header or self-test byte read non-zero.");

  a_win_space_copy: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.dword == 10'h004
                                     |=> CFG_RDATA[0] == $past(WINDOW0_SETUP.space_select))
    else $error("Window space bit does not copy the setup.");

  a_upper_narrow: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.dword == 10'h005
                                   && !wide_mode |=> CFG_RDATA == 32'h0000_0000)
    else $error("Upper base word read non-zero outside 64-bit memory mode.");

  // The codes are parameters, so a wrong lane order would still pass a test that uses equal halves.
  a_id_read: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.dword == 10'h000
                              |=> CFG_RDATA == {PART_CODE, VENDOR_CODE})
    else $error("Identification codes read wrong.");

endmodule

// ---- ntb_cfg_map.svh ----
// Offsets, field positions, reset values and fixed codes of the endpoint configuration header.
`ifndef NTB_CFG_MAP_SVH
`define NTB_CFG_MAP_SVH

`define NTB_OFS_MAKER_IDENTITY   12'h000
`define NTB_OFS_PART_IDENTITY    12'h002
`define NTB_OFS_COMMAND_CONTROL  12'h004
`define NTB_OFS_STATUS_FLAGS     12'h006
`define NTB_OFS_REVISION_CODE    12'h008
`define NTB_OFS_CLASS_CODE       12'h009
`define NTB_OFS_LINE_SIZE_HINT   12'h00C
`define NTB_OFS_LATENCY_TIMER    12'h00D
`define NTB_OFS_HEADER_LAYOUT    12'h00E
`define NTB_OFS_SELF_TEST        12'h00F
`define NTB_OFS_WINDOW0_BASE     12'h010
`define NTB_OFS_WINDOW1_BASE     12'h014

`define NTB_CMD_IO_SPACE_EN      0
`define NTB_CMD_MEM_SPACE_EN     1
`define NTB_CMD_REQ_FORWARD_EN   2
`define NTB_CMD_POISON_REPORT_EN 6
`define NTB_CMD_ERROR_MSG_EN     8
`define NTB_CMD_LEGACY_IRQ_OFF   10

`define NTB_STS_LEGACY_IRQ_PEND  3
`define NTB_STS_CAP_LIST_FLAG    4
`define NTB_STS_MASTER_POISON    8
`define NTB_STS_GOT_CPL_ABORT    12
`define NTB_STS_GOT_UNSUP_REQ    13
`define NTB_STS_SENT_SYS_ERROR   14
`define NTB_STS_POISON_SEEN      15

`define NTB_RST_COMMAND          16'h0000
`define NTB_RST_STATUS_W1C       16'h0000
`define NTB_RST_LINE_SIZE        8'h00
`define NTB_RST_BASE             64'h0000_0000_0000_0000
`define NTB_PROG_INTERFACE       8'h00
`define NTB_SUB_CLASS            8'h80
`define NTB_BASE_CLASS           8'h06
`define NTB_LATENCY_TIMER        8'h00
`define NTB_HEADER_LAYOUT        8'h00
`define NTB_SELF_TEST            8'h00
`define NTB_ADDR_TYPE_32         2'h0
`define NTB_ADDR_TYPE_64         2'h2
`define NTB_BASE_LSB             4

`endif

// ---- ntb_cfg_pkg.sv ----
// Types shared by the endpoint configuration header block.
package ntb_cfg_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [9:0]  dword;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } ntb_cfg_req_t;

  typedef struct packed {
    logic       space_select;
    logic [1:0] addr_type;
    logic       fetch_ahead_flag;
    logic [5:0] size_log2;
  } ntb_win_setup_t;

  typedef struct packed {
    logic poison_cpl_or_wr;
    logic poison_tlp;
    logic got_cpl_abort;
    logic got_unsup_req;
    logic error_detected;
  } ntb_events_t;

  typedef struct packed {
    logic io_hit;
    logic mem_hit;
    logic fwd_req;
    logic fwd_nonposted;
  } ntb_traffic_t;

endpackage

// ---- ntb_host_model.sv ----
// Host-side model that issues configuration reads and writes to the header block.
`timescale 1ns/100ps
module ntb_host_model
  import ntb_cfg_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          cfg_ack,
  input  wire logic [31:0]   cfg_rdata,
  output ntb_cfg_req_t       cfg_req
);
  initial begin
    cfg_req = '0;
    cfg_req.wdata = 32'h5A5A_5A5A;
  end

  // One request, valid for a single cycle, then a bounded wait for the acknowledge.
  task automatic xfer(input logic wr, input logic [9:0] dw, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    rd = 32'h0000_0000;
    @(negedge clock);
    cfg_req.valid = 1'b1;
    cfg_req.write = wr;
    cfg_req.dword = dw;
    cfg_req.byte_en = be;
    cfg_req.wdata = wd;
    @(negedge clock);
    cfg_req.valid = 1'b0;
    // Released data is inverted so a stale value can never pass for a fresh one.
    cfg_req.wdata = ~wd;
    cfg_req.dword = ~dw;
    while (n < 4 && ok == 1'b0) begin
      if (cfg_ack === 1'b1) begin
        ok = 1'b1;
        rd = cfg_rdata;
      end else begin
        @(negedge clock);
        n++;
      end
    end
  endtask

  // Status flags are cleared by writing one to them, only on the status byte lanes.
  task automatic clear_flags(input logic [15:0] m, output logic ok);
    logic [31:0] d;
    xfer(1'b1, 10'h001, 4'b1100, {m, 16'h0000}, d, ok);
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the endpoint configuration header block.
`timescale 1ns/100ps
module tb_top;
  import ntb_cfg_pkg::*;
  localparam logic [15:0] VEN = 16'hA5C3;  // Arbitrary value.
  localparam logic [15:0] PRT = 16'h3C5A;  // Arbitrary value.

  logic           clock;
  logic           rst_b;
  ntb_cfg_req_t   cfg_req;
  logic           cfg_ack;
  logic [31:0]    cfg_rdata;
  ntb_win_setup_t setup;
  ntb_events_t    events;
  logic           own_irq;
  ntb_traffic_t   traffic;
  logic           io_acc;
  logic           mem_acc;
  logic           fwd_allow;
  logic           fwd_ur;
  logic           err_send;
  logic [63:0]    base;
  logic [63:0]    mask;
  int             err_total;
  int             n_compared;
  int             cycles;

  ntb_cfg_header #(.VENDOR_CODE(VEN), .PART_CODE(PRT), .REVISION_INIT(8'h00)) uut (
    .CLOCK(clock), .RST_B(rst_b), .CFG_REQ(cfg_req), .CFG_ACK(cfg_ack), .CFG_RDATA(cfg_rdata),
    .WINDOW0_SETUP(setup), .EVENTS(events), .OWN_IRQ_PENDING(own_irq), .TRAFFIC(traffic),
    .IO_ACCEPT(io_acc), .MEM_ACCEPT(mem_acc), .FWD_ALLOW(fwd_allow), .FWD_REPLY_UR(fwd_ur),
    .ERR_MSG_SEND(err_send), .WINDOW0_BASE(base), .WINDOW0_MASK(mask));

  ntb_host_model host (.clock(clock), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic close_out();
    $display("compared %0d values, %0d mismatches", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hang must still end in the verdict; the tests need only about 110 cycles.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [9:0] dw, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    host.xfer(1'b0, dw, 4'hF, 32'h0000_0000, d, ok);
    chk(64'(ok), 64'h1);
    chk(64'(d), 64'(exp));
  endtask

  task automatic w(input logic [9:0] dw, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] d;
    logic        ok;
    host.xfer(1'b1, dw, be, wd, d, ok);
    chk(64'(ok), 64'h1);
  endtask

  task automatic clr(input logic [15:0] m);
    logic ok;
    host.clear_flags(m, ok);
    chk(64'(ok), 64'h1);
  endtask

  // Event pulse lasts one cycle; the error message output is looked at in the following cycle.
  task automatic pulse(input ntb_events_t e, input logic send);
    @(negedge clock);
    events = e;
    @(negedge clock);
    events = '0;
    chk(64'(err_send), 64'(send));
    @(negedge clock);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, %0d mismatches so far", name, err_total);
  endtask

  initial begin
    rst_b = 1'b0;
    setup = '0;
    events = '0;
    own_irq = 1'b0;
    traffic = '0;
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    rchk(10'h000, {PRT, VEN});
    rchk(10'h001, 32'h0010_0000);
    rchk(10'h002, 32'h0680_0000);
    rchk(10'h003, 32'h0000_0000);
    rchk(10'h004, 32'h0000_0000);
    rchk(10'h005, 32'h0000_0000);
    rchk(10'h007, 32'h0000_0000);
    w(10'h000, 4'hF, 32'hFFFF_FFFF);
    rchk(10'h000, {PRT, VEN});
    w(10'h002, 4'b1110, 32'hFFFF_FFFF);
    rchk(10'h002, 32'h0680_0000);
    w(10'h003, 4'hF, 32'hFFFF_FFA5);
    rchk(10'h003, 32'h0000_00A5);
    w(10'h002, 4'b0001, 32'h0000_0033);
    rchk(10'h002, 32'h0680_0033);
    w(10'h001, 4'b0011, 32'h0000_FFFF);
    rchk(10'h001, 32'h0010_0547);
    end_test("registers");
    for (int i = 0; i < 2; i++) begin
      w(10'h001, 4'b0011, i ? 32'h0000_0007 : 32'h0000_0000);
      traffic = 4'b1111;
      #1;
      chk(64'(io_acc), 64'(i));
      chk(64'(mem_acc), 64'(i));
      chk(64'(fwd_allow), 64'(i));
      chk(64'(fwd_ur), 64'(1 - i));
      traffic = 4'b0000;
    end
    end_test("traffic");
    w(10'h001, 4'b0011, 32'h0000_0000);
    pulse(5'h10, 1'b0);
    pulse(5'h01, 1'b0);
    rchk(10'h001, 32'h0010_0000);
    w(10'h001, 4'b0011, 32'h0000_0140);
    pulse(5'h10, 1'b0);
    rchk(10'h001, 32'h0110_0140);
    pulse(5'h08, 1'b0);
    rchk(10'h001, 32'h8110_0140);
    pulse(5'h04, 1'b0);
    pulse(5'h02, 1'b0);
    rchk(10'h001, 32'hB110_0140);
    pulse(5'h01, 1'b1);
    rchk(10'h001, 32'hF110_0140);
    own_irq = 1'b1;
    rchk(10'h001, 32'hF118_0140);
    own_irq = 1'b0;
    clr(16'h0000);
    rchk(10'h001, 32'hF110_0140);
    clr(16'h1000);
    rchk(10'h001, 32'hE110_0140);
    clr(16'hE100);
    rchk(10'h001, 32'h0010_0140);
    end_test("status");
    setup = '{1'b0, 2'h0, 1'b1, 6'h0c};
    rchk(10'h004, 32'h0000_0008);
    w(10'h004, 4'hF, 32'hFFFF_FFFF);
    rchk(10'h004, 32'hFFFF_F008);
    chk(base, 64'h0000_0000_FFFF_F000);
    w(10'h005, 4'hF, 32'hFFFF_FFFF);
    rchk(10'h005, 32'h0000_0000);
    setup = '{1'b1, 2'h2, 1'b1, 6'h0c};
    rchk(10'h004, 32'hFFFF_F001);
    setup = '{1'b0, 2'h2, 1'b0, 6'h0c};
    w(10'h005, 4'hF, 32'hDEAD_BEEF);
    rchk(10'h005, 32'hDEAD_BEEF);
    rchk(10'h004, 32'hFFFF_F004);
    chk(base, 64'hDEAD_BEEF_FFFF_F000);
    chk(mask, 64'hFFFF_FFFF_FFFF_F000);
    setup = '{1'b0, 2'h0, 1'b0, 6'h00};
    rchk(10'h004, 32'h0000_0000);
    end_test("window");
    close_out();
  end
endmodule
